// ===== design/adc_clk_test_pkg.sv
// package: register map, field layout and test pattern constants
`default_nettype none
package adc_clk_test_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CLOCK_STABILIZER = 8'h09;
    localparam logic [7:0] ADDR_CLOCK_DIVIDE = 8'h0B;
    localparam logic [7:0] ADDR_ENHANCEMENT = 8'h0C;
    localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0D;
    localparam logic [7:0] ADDR_USER_PATTERN1_LOW = 8'h19;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int STABILIZER_BIT = 0;
    localparam int DIVIDE_LSB = 0;
    localparam int DIVIDE_WIDTH = 3;
    localparam int CHOP_BIT = 2;
    localparam int LFSR_LONG_RESET_BIT = 5;
    localparam int LFSR_SHORT_RESET_BIT = 4;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    localparam int SAMPLE_WIDTH = 14;
    localparam int CHANNELS = 2;

    // ------------------------------------------------------------------
    // test select codes and user modes
    // ------------------------------------------------------------------
    localparam logic [3:0] TEST_NORMAL = 4'h0;
    localparam logic [3:0] TEST_MIDSCALE = 4'h1;
    localparam logic [3:0] TEST_POS_FULL_SCALE = 4'h2;
    localparam logic [3:0] TEST_NEG_FULL_SCALE = 4'h3;
    localparam logic [3:0] TEST_CHECKERBOARD = 4'h4;
    localparam logic [3:0] TEST_PSEUDORANDOM_LONG = 4'h5;
    localparam logic [3:0] TEST_PSEUDORANDOM_SHORT = 4'h6;
    localparam logic [3:0] TEST_WORD_TOGGLE = 4'h7;
    localparam logic [3:0] TEST_USER_INPUT = 4'h8;
    localparam logic [3:0] TEST_BIT_TOGGLE = 4'h9;
    localparam logic [3:0] TEST_SYNC = 4'hA;
    localparam logic [3:0] TEST_ONE_BIT_HIGH = 4'hB;

    localparam logic [1:0] USER_SINGLE = 2'h0;
    localparam logic [1:0] USER_ALTERNATE = 2'h1;
    localparam logic [1:0] USER_SINGLE_ONCE = 2'h2;
    localparam logic [1:0] USER_ALTERNATE_ONCE = 2'h3;

    // ------------------------------------------------------------------
    // pattern words and generator seeds
    // ------------------------------------------------------------------
    localparam logic [13:0] WORD_MIDSCALE = 14'h2000;
    localparam logic [13:0] WORD_ALL_ONES = 14'h3FFF;
    localparam logic [13:0] WORD_ALL_ZEROS = 14'h0000;
    localparam logic [13:0] WORD_CHECKER_A = 14'h2AAA;
    localparam logic [13:0] WORD_CHECKER_B = 14'h1555;
    localparam logic [13:0] WORD_SYNC = 14'h3F80;
    localparam logic [13:0] WORD_ONE_BIT_HIGH = 14'h0001;
    localparam logic [22:0] SEED_PSEUDORANDOM_LONG = 23'h7FFFFF;
    localparam logic [8:0] SEED_PSEUDORANDOM_SHORT = 9'h1FF;

    typedef struct packed {
        logic [1:0] user_mode;
        logic [3:0] select;
    } test_ctrl_s;

    typedef struct packed {
        logic phase;
        logic [1:0] shown;
    } channel_state_s;

endpackage
`default_nettype wire

// ===== design/adc_clock_and_test_pattern_ctrl.sv
// clock control and output test pattern registers of the dual converter
`default_nettype none
module adc_clock_and_test_pattern_ctrl (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic [1:0] channel_enable,
    output logic [7:0] reg_rdata,
    input wire logic [13:0] user_pattern2,
    input wire logic [13:0] conv_data_a,
    input wire logic [13:0] conv_data_b,
    output logic [13:0] out_data_a,
    output logic [13:0] out_data_b,
    output logic stabilizer_enable,
    output logic [2:0] clock_divide_ratio,
    output logic chop_enable
);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic stabilizer, next_stabilizer;
    logic [2:0] divide, next_divide;
    logic chop, next_chop;
    logic lfsr_long_reset, next_lfsr_long_reset;
    logic lfsr_short_reset, next_lfsr_short_reset;
    logic [7:0] user_pattern1_low, next_user_pattern1_low;
    adc_clk_test_pkg::test_ctrl_s test_ctrl [2];
    adc_clk_test_pkg::test_ctrl_s next_test_ctrl [2];
    logic [1:0] test_written;
    int rd_ch;

    always_comb begin
        next_stabilizer = stabilizer;
        next_divide = divide;
        next_chop = chop;
        next_lfsr_long_reset = lfsr_long_reset;
        next_lfsr_short_reset = lfsr_short_reset;
        next_user_pattern1_low = user_pattern1_low;
        next_test_ctrl = test_ctrl;
        test_written = 2'h0;
        if (reg_write) begin
            case (reg_addr)
                adc_clk_test_pkg::ADDR_CLOCK_STABILIZER: begin
                    next_stabilizer = reg_wdata[adc_clk_test_pkg::STABILIZER_BIT];
                end
                adc_clk_test_pkg::ADDR_CLOCK_DIVIDE: begin
                    next_divide = reg_wdata[adc_clk_test_pkg::DIVIDE_LSB +: 3];
                end
                adc_clk_test_pkg::ADDR_ENHANCEMENT: begin
                    next_chop = reg_wdata[adc_clk_test_pkg::CHOP_BIT];
                end
                adc_clk_test_pkg::ADDR_TEST_PATTERN: begin
                    // generator resets are shared, select and mode per channel
                    next_lfsr_long_reset =
                        reg_wdata[adc_clk_test_pkg::LFSR_LONG_RESET_BIT];
                    next_lfsr_short_reset =
                        reg_wdata[adc_clk_test_pkg::LFSR_SHORT_RESET_BIT];
                    for (int c = 0; c < 2; c++) begin
                        if (channel_enable[c]) begin
                            next_test_ctrl[c] = {reg_wdata[7:6], reg_wdata[3:0]};
                            test_written[c] = 1'b1;
                        end
                    end
                end
                adc_clk_test_pkg::ADDR_USER_PATTERN1_LOW: begin
                    next_user_pattern1_low = reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stabilizer <= 1'b0;
            divide <= 3'h0;
            chop <= 1'b0;
            lfsr_long_reset <= 1'b0;
            lfsr_short_reset <= 1'b0;
            user_pattern1_low <= adc_clk_test_pkg::RESET_VALUE;
            test_ctrl[0] <= '0;
            test_ctrl[1] <= '0;
        end else begin
            stabilizer <= next_stabilizer;
            divide <= next_divide;
            chop <= next_chop;
            lfsr_long_reset <= next_lfsr_long_reset;
            lfsr_short_reset <= next_lfsr_short_reset;
            user_pattern1_low <= next_user_pattern1_low;
            test_ctrl <= next_test_ctrl;
        end
    end

    assign stabilizer_enable = stabilizer;
    assign clock_divide_ratio = divide;
    assign chop_enable = chop;

    // readback of the test register comes from the lowest enabled channel
    always_comb begin
        rd_ch = (!channel_enable[0] && channel_enable[1]) ? 1 : 0;
        case (reg_addr)
            adc_clk_test_pkg::ADDR_CLOCK_STABILIZER: reg_rdata = {7'h00, stabilizer};
            adc_clk_test_pkg::ADDR_CLOCK_DIVIDE: reg_rdata = {5'h00, divide};
            adc_clk_test_pkg::ADDR_ENHANCEMENT: reg_rdata = {5'h00, chop, 2'h0};
            adc_clk_test_pkg::ADDR_TEST_PATTERN: reg_rdata = {test_ctrl[rd_ch].user_mode,
                lfsr_long_reset, lfsr_short_reset, test_ctrl[rd_ch].select};
            adc_clk_test_pkg::ADDR_USER_PATTERN1_LOW: reg_rdata = user_pattern1_low;
            default: reg_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // pseudorandom generators
    // ------------------------------------------------------------------
    logic [22:0] lfsr_long, next_lfsr_long;
    logic [8:0] lfsr_short, next_lfsr_short;

    always_comb begin
        // held at seed while the reset bit stays set
        if (lfsr_long_reset) begin
            next_lfsr_long = adc_clk_test_pkg::SEED_PSEUDORANDOM_LONG;
        end else begin
            next_lfsr_long = {lfsr_long[21:0], lfsr_long[22] ^ lfsr_long[17]};
        end
        if (lfsr_short_reset) begin
            next_lfsr_short = adc_clk_test_pkg::SEED_PSEUDORANDOM_SHORT;
        end else begin
            next_lfsr_short = {lfsr_short[7:0], lfsr_short[8] ^ lfsr_short[4]};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lfsr_long <= adc_clk_test_pkg::SEED_PSEUDORANDOM_LONG;
            lfsr_short <= adc_clk_test_pkg::SEED_PSEUDORANDOM_SHORT;
        end else begin
            lfsr_long <= next_lfsr_long;
            lfsr_short <= next_lfsr_short;
        end
    end

    // ------------------------------------------------------------------
    // per channel pattern selection
    // ------------------------------------------------------------------
    function automatic logic [13:0] pattern_word(
        input adc_clk_test_pkg::test_ctrl_s ctrl,
        input adc_clk_test_pkg::channel_state_s st,
        input logic [13:0] conv,
        input logic [13:0] user1,
        input logic [13:0] user2,
        input logic [13:0] pnl,
        input logic [13:0] pns
    );
        logic [13:0] user_word;
        logic once;
        user_word = (ctrl.user_mode[0] && st.phase) ? user2 : user1;
        once = ctrl.user_mode[1];
        // once modes fall silent after one or two words
        if (once && (st.shown > {1'b0, ctrl.user_mode[0]})) begin
            user_word = adc_clk_test_pkg::WORD_ALL_ZEROS;
        end
        case (ctrl.select)
            adc_clk_test_pkg::TEST_NORMAL: return conv;
            adc_clk_test_pkg::TEST_MIDSCALE: return adc_clk_test_pkg::WORD_MIDSCALE;
            adc_clk_test_pkg::TEST_POS_FULL_SCALE: return adc_clk_test_pkg::WORD_ALL_ONES;
            adc_clk_test_pkg::TEST_NEG_FULL_SCALE: return adc_clk_test_pkg::WORD_ALL_ZEROS;
            adc_clk_test_pkg::TEST_CHECKERBOARD:
                return st.phase ? adc_clk_test_pkg::WORD_CHECKER_B
                                : adc_clk_test_pkg::WORD_CHECKER_A;
            adc_clk_test_pkg::TEST_PSEUDORANDOM_LONG: return pnl;
            adc_clk_test_pkg::TEST_PSEUDORANDOM_SHORT: return pns;
            adc_clk_test_pkg::TEST_WORD_TOGGLE:
                return st.phase ? adc_clk_test_pkg::WORD_ALL_ZEROS
                                : adc_clk_test_pkg::WORD_ALL_ONES;
            adc_clk_test_pkg::TEST_USER_INPUT: return user_word;
            adc_clk_test_pkg::TEST_BIT_TOGGLE: return adc_clk_test_pkg::WORD_CHECKER_A;
            adc_clk_test_pkg::TEST_SYNC: return adc_clk_test_pkg::WORD_SYNC;
            adc_clk_test_pkg::TEST_ONE_BIT_HIGH: return adc_clk_test_pkg::WORD_ONE_BIT_HIGH;
            // unlisted codes give normal data rather than an undefined word
            default: return conv;
        endcase
    endfunction

    adc_clk_test_pkg::channel_state_s ch_state [2];
    adc_clk_test_pkg::channel_state_s next_ch_state [2];
    logic [13:0] next_out [2];
    logic [13:0] out_q [2];
    logic [13:0] user1_word;

    always_comb begin
        user1_word = {6'h00, user_pattern1_low};
        for (int c = 0; c < 2; c++) begin
            next_out[c] = pattern_word(test_ctrl[c], ch_state[c],
                (c == 0) ? conv_data_a : conv_data_b, user1_word, user_pattern2,
                lfsr_long[13:0], {5'h00, lfsr_short});
            next_ch_state[c].phase = ~ch_state[c].phase;
            next_ch_state[c].shown = (ch_state[c].shown == 2'h3) ? 2'h3
                                   : ch_state[c].shown + 2'h1;
            // a fresh write restarts the alternate phase and the once count
            if (test_written[c]) begin
                next_ch_state[c] = '0;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ch_state[0] <= '0;
            ch_state[1] <= '0;
            out_q[0] <= 14'h0000;
            out_q[1] <= 14'h0000;
        end else begin
            ch_state <= next_ch_state;
            out_q <= next_out;
        end
    end

    assign out_data_a = out_q[0];
    assign out_data_b = out_q[1];

endmodule
`default_nettype wire

// ===== dv/adc_ctrl_chk.sv
// checker: assertions on register and lane ports
`default_nettype none
module adc_ctrl_chk (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic [1:0] channel_enable,
    input wire logic [7:0] reg_rdata,
    input wire logic [13:0] conv_data_a,
    input wire logic [13:0] out_data_a,
    input wire logic stabilizer_enable,
    input wire logic [2:0] clock_divide_ratio,
    input wire logic chop_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic w09, w0b, w0c, wa;
    assign w09 = reg_write && reg_addr == 8'h09;
    assign w0b = reg_write && reg_addr == 8'h0B;
    assign w0c = reg_write && reg_addr == 8'h0C;
    assign wa = reg_write && reg_addr == 8'h0D && channel_enable == 2'b01;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    chk_stab_write: assert property
        (w09 |=> stabilizer_enable == $past(reg_wdata[0])) else $error("bad stabilizer");
    chk_stab_hold: assert property
        (!w09 |=> $stable(stabilizer_enable)) else $error("stabilizer moved");
    chk_div_write: assert property
        (w0b |=> clock_divide_ratio == $past(reg_wdata[2:0])) else $error("bad divide");
    chk_chop_write: assert property
        (w0c |=> chop_enable == $past(reg_wdata[2])) else $error("bad chop");
    chk_read_stab: assert property
        (reg_addr == 8'h09 |-> reg_rdata == {7'h00, stabilizer_enable}) else $error("rd 09");
    chk_read_div: assert property
        (reg_addr == 8'h0B |-> reg_rdata == {5'h00, clock_divide_ratio}) else $error("rd 0B");
    chk_read_chop: assert property
        (reg_addr == 8'h0C |-> reg_rdata == {5'h00, chop_enable, 2'h0}) else $error("rd 0C");
    chk_read_unmapped: assert property
        (!(reg_addr inside {8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h19}) |-> reg_rdata == 8'h00)
        else $error("unmapped read");
    chk_test_read: assert property
        (wa ##1 (reg_addr == 8'h0D && channel_enable == 2'b01) |-> reg_rdata == $past(reg_wdata))
        else $error("rd 0D");
    chk_normal_pass: assert property
        (wa && reg_wdata[3:0] == 4'h0 |=> ##1 out_data_a == $past(conv_data_a))
        else $error("normal data lost");
    chk_midscale: assert property
        (wa && reg_wdata[3:0] == 4'h1 |=> ##1 out_data_a == 14'h2000) else $error("midscale");
endmodule
`default_nettype wire

// ===== dv/serial_host_model.sv
// host model: serial port core side issuing register writes and reads
`default_nettype none
module serial_host_model (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic [1:0] channel_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        channel_enable = 2'b01;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] ce);
        @(posedge clock);
        #2;
        reg_addr = a;
        reg_wdata = d;
        channel_enable = ce;
        reg_write = 1'b1;
        @(posedge clock);
        #2;
        reg_write = 1'b0;
        // stale byte must not pass for valid data
        reg_wdata = ~d;
    endtask
    task automatic sel(input logic [7:0] a, input logic [1:0] ce);
        @(posedge clock);
        #2;
        reg_addr = a;
        channel_enable = ce;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_adc_clock_and_test_pattern_ctrl.sv
// testbench: register access and output lane pattern checks
`default_nettype none
module tb_adc_clock_and_test_pattern_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_write, stabilizer_enable, chop_enable;
    logic [1:0] channel_enable;
    logic [2:0] clock_divide_ratio;
    logic [13:0] out_data_a, out_data_b;
    logic [13:0] user_pattern2 = 14'h0155;
    logic [13:0] conv_data_a = 14'h0ABC;
    logic [13:0] conv_data_b = 14'h1357;
    int n_errors = 0;
    int num_checks = 0;
    logic [7:0] ra [5] = '{8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h0A};
    logic [7:0] rm [5] = '{8'h01, 8'h07, 8'h04, 8'hFF, 8'h00};
    logic [3:0] cd [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'hA, 4'hB, 4'hC};
    logic [13:0] w0 [10] = '{14'h0ABC, 14'h2000, 14'h3FFF, 14'h0000, 14'h2AAA,
        14'h3FFF, 14'h2AAA, 14'h3F80, 14'h0001, 14'h0ABC};
    logic [13:0] w1 [10] = '{14'h0ABC, 14'h2000, 14'h3FFF, 14'h0000, 14'h1555,
        14'h0000, 14'h2AAA, 14'h3F80, 14'h0001, 14'h0ABC};
    always #25 clock = ~clock;
    serial_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .channel_enable(channel_enable));
    adc_clock_and_test_pattern_ctrl dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .channel_enable(channel_enable),
        .reg_rdata(reg_rdata), .user_pattern2(user_pattern2), .conv_data_a(conv_data_a),
        .conv_data_b(conv_data_b), .out_data_a(out_data_a), .out_data_b(out_data_b),
        .stabilizer_enable(stabilizer_enable), .clock_divide_ratio(clock_divide_ratio),
        .chop_enable(chop_enable));
    task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] ce, input logic [7:0] exp);
        host.sel(a, ce);
        #1;
        cmp({6'h00, reg_rdata}, {6'h00, exp});
    endtask
    task automatic lane(input logic [13:0] exp);
        @(posedge clock);
        #1;
        cmp(out_data_a, exp);
    endtask
    function automatic logic [13:0] uexp(input logic [1:0] m, input int k);
        if (m[1] && k > int'(m[0])) return 14'h0000;
        return (m[0] && k[0]) ? 14'h0155 : 14'h005A;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        #2;
        arst_n = 1'b1;
        foreach (ra[i]) begin
            rd(ra[i], 2'b01, 8'h00);
            host.wr(ra[i], 8'hFF, 2'b01);
            rd(ra[i], 2'b01, rm[i]);
        end
        cmp({9'h000, chop_enable, stabilizer_enable, clock_divide_ratio}, 14'h001F);
        rd(8'h0D, 2'b10, 8'h30);
        foreach (ra[i]) host.wr(ra[i], 8'h00, 2'b01);
        cmp({9'h000, chop_enable, stabilizer_enable, clock_divide_ratio}, 14'h0000);
        foreach (cd[i]) begin
            host.wr(8'h0D, {4'hC, cd[i]}, 2'b01);
            lane(w0[i]);
            lane(w1[i]);
            cmp(out_data_b, conv_data_b);
        end
        // generator state seen one sample late, so skip a sample
        host.wr(8'h0D, 8'h25, 2'b01);
        @(posedge clock);
        lane(14'h3FFF);
        lane(14'h3FFF);
        host.wr(8'h0D, 8'h05, 2'b01);
        repeat (20) @(posedge clock);
        #1;
        num_checks++;
        if (out_data_a === 14'h3FFF) begin
            n_errors++;
            $display("[FAIL] %0t long sequence stuck at seed", $time);
        end
        host.wr(8'h0D, 8'h20, 2'b10);
        @(posedge clock);
        lane(14'h3FFF);
        host.wr(8'h0D, 8'h16, 2'b01);
        @(posedge clock);
        lane(14'h01FF);
        host.wr(8'h19, 8'h5A, 2'b01);
        rd(8'h19, 2'b01, 8'h5A);
        for (int m = 0; m < 4; m++) begin
            host.wr(8'h0D, {m[1:0], 6'h08}, 2'b01);
            for (int k = 0; k < 4; k++) lane(uexp(m[1:0], k));
        end
        // both lanes, then channel B alone, must follow their own select
        host.wr(8'h0D, 8'h01, 2'b11);
        lane(14'h2000);
        cmp(out_data_b, 14'h2000);
        rd(8'h0D, 2'b10, 8'h01);
        host.wr(8'h0D, 8'h04, 2'b10);
        lane(14'h2000);
        cmp(out_data_b, 14'h2AAA);
        // mid-run reset must clear nonzero clock settings and lane B
        host.wr(8'h09, 8'h01, 2'b01);
        host.wr(8'h0B, 8'h05, 2'b01);
        @(posedge clock);
        #2;
        arst_n = 1'b0;
        #1;
        cmp(out_data_b, 14'h0000);
        cmp({9'h000, chop_enable, stabilizer_enable, clock_divide_ratio}, 14'h0000);
        repeat (2) @(posedge clock);
        #2;
        arst_n = 1'b1;
        rd(8'h0D, 2'b11, 8'h00);
        lane(14'h0ABC);
        report_and_stop();
    end
    initial begin
        #100us;
        n_errors++;
        report_and_stop();
    end
endmodule
bind adc_clock_and_test_pattern_ctrl adc_ctrl_chk chk (.clock(clock), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .channel_enable(channel_enable), .reg_rdata(reg_rdata), .conv_data_a(conv_data_a),
    .out_data_a(out_data_a), .stabilizer_enable(stabilizer_enable),
    .clock_divide_ratio(clock_divide_ratio), .chop_enable(chop_enable));
`default_nettype wire
